// ==== design/spb_pkg.sv ====
// Shared constants and types of the serial port break and sync master transmit block
// ==========================================================================
// How it works
// - Armed wake idles the port; wake sets receive flag; next rising edge clears arm.
// - Reading the receive buffer clears the wake receive flag; data read is dummy.
// - Wake arm auto-clear needs no core phase clocks, even during oscillator start-up.
// - Break frame is one start bit, twelve zero bits, one stop bit.
// - Break-send plus transmit enable at shifter load sends break, data ignored.
// - Break-send clears after break stop bit, so a preloaded byte follows normally.
// - Shifter-empty flag shows break frames just like ordinary frames.
// - Armed wake watches two line transitions: flags on the falling one, disarms on the rising one.
// - Clock-source plus synchronous bit select sync master; port enable claims pins.
// - Synchronous mode is half duplex: transmit and receive block each other; here only receive enable blocks transmit loads.
// - Master drives shift clock; polarity bit set idles it high, clear idles low.
// - Shifter reloads only after last bit, then at once from a waiting buffer.
// - Buffer-to-shifter move takes one cycle, then buffer-empty flag sets.
// - Buffer-empty flag ignores its enable, ignores writes, clears on buffer write.
// - Shifter-empty flag is read-only, set when shifter empty, no interrupt.
// - Nine-bit mode sends the preloaded ninth bit with the eight data bits.
// - Wake event is a receive-line falling edge, seen only while armed.
package spb_pkg;

    // ==========================================================================
    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS   = 8'h00;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h04;
    localparam logic [7:0] OFS_RX_CTL  = 8'h08;
    localparam logic [7:0] OFS_TX_BUF  = 8'h0c;
    localparam logic [7:0] OFS_TX_CTL  = 8'h10;
    localparam logic [7:0] OFS_RATE    = 8'h14;
    localparam logic [7:0] OFS_DIV_HI  = 8'h18;
    localparam logic [7:0] OFS_DIV_LO  = 8'h1c;
    localparam logic [7:0] OFS_RX_BUF  = 8'h20;

    // ==========================================================================
    // Field positions
    localparam int BIT_RX_READY   = 5;
    localparam int BIT_TX_EMPTY   = 4;
    localparam int BIT_PORT_EN    = 7;
    localparam int BIT_RX_SINGLE  = 5;
    localparam int BIT_RX_CONT    = 4;
    localparam int BIT_CLK_MASTER = 7;
    localparam int BIT_NINE_TX    = 6;
    localparam int BIT_TX_EN      = 5;
    localparam int BIT_SYNC       = 4;
    localparam int BIT_BRK_SEND   = 3;
    localparam int BIT_HIGH_RATE  = 2;
    localparam int BIT_SH_EMPTY   = 1;
    localparam int BIT_NINTH      = 0;
    localparam int BIT_RX_IDLE    = 6;
    localparam int BIT_CLK_POL    = 4;
    localparam int BIT_WIDE_DIV   = 3;
    localparam int BIT_WAKE_ARM   = 1;

    // ==========================================================================
    // Writable masks and reset values
    localparam logic [7:0] RX_CTL_WR_MASK = 8'hf8;
    localparam logic [7:0] TX_CTL_WR_MASK = 8'hfd;
    localparam logic [7:0] RATE_WR_MASK   = 8'h1b;
    localparam logic [7:0] CTL_RESET      = 8'h00;

    // ==========================================================================
    // Frame shapes (value is bits per frame) and prescaler limits (value is steps per tick minus one)
    localparam logic [3:0] BITS_BREAK   = 4'he;
    localparam logic [3:0] BITS_ASYNC8  = 4'ha;
    localparam logic [3:0] BITS_ASYNC9  = 4'hb;
    localparam logic [3:0] BITS_SYNC8   = 4'h8;
    localparam logic [3:0] BITS_SYNC9   = 4'h9;
    localparam logic [5:0] PRE_SYNC     = 6'h01;
    localparam logic [5:0] PRE_FAST     = 6'h03;
    localparam logic [5:0] PRE_MID      = 6'h0f;
    localparam logic [5:0] PRE_SLOW     = 6'h3f;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_ASYNC,
        TX_SYNC
    } spb_tx_state_t;

endpackage

// ==== design/spb_baud_div.sv ====
// Rate divider producing one-cycle tick enables for the transmit shifter
module spb_baud_div (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        restart_in,
    input  wire logic [15:0] divisor_in,
    input  wire logic [5:0]  pre_max_in,
    output logic             tick_out
);

    typedef struct packed {
        logic [15:0] cnt;
        logic [5:0]  pre;
        logic        tick;
    } spb_div_state_t;

    spb_div_state_t st_r;
    spb_div_state_t st_nxt;

    // ==========================================================================
    // Counter chain: divisor+1 cycles per prescale step
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (restart_in) begin
            // Realign so the first bit of a frame gets its full width
            st_nxt.cnt = divisor_in;
            st_nxt.pre = 6'h00;
        end else if (st_r.cnt == 16'h0000) begin
            st_nxt.cnt = divisor_in;
            if (st_r.pre >= pre_max_in) begin
                st_nxt.pre  = 6'h00;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.pre = st_r.pre + 6'h01;
            end
        end else begin
            st_nxt.cnt = st_r.cnt - 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_out = st_r.tick;

endmodule

// ==== design/spb_top.sv ====
// Serial port with break generation, wake arming and synchronous master transmit
//
// Implementation choices: the APB interface to the registers and the register addresses.
module spb_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic              sys_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic              shift_data_pin_in,
    output logic                   shift_data_pin_out,
    output logic                   shift_data_pin_oe_n_out,
    output logic                   shift_clock_pin_out,
    output logic                   shift_clock_pin_oe_n_out
);

    if (ADDR_W < 8) begin : g_chk
        $error("spb_top: ADDR_W must be at least 8");
    end

    typedef struct packed {
        logic [7:0]            irq_en;
        logic [7:0]            rx_ctl;
        logic [7:0]            tx_ctl;
        logic [7:0]            rate;
        logic [7:0]            div_hi;
        logic [7:0]            div_lo;
        logic [7:0]            buf_data;
        logic                  buf_full;
        logic                  tx_empty_flag;
        logic                  rx_ready_flag;
        spb_pkg::spb_tx_state_t tx_st;
        logic [13:0]           sh;
        logic [3:0]            bits_left;
        logic                  is_break;
        logic                  phase;
        logic                  rx_s1;
        logic                  rx_s2;
        logic                  rx_s3;
        logic                  rx_level;
        logic                  wake_seen;
        logic                  data_line;
        logic                  data_oe_n;
        logic                  clk_line;
        logic                  clk_oe_n;
        logic [31:0]           prdata;
        logic                  perr;
    } spb_state_t;

    localparam spb_state_t ST_RESET = '{
        irq_en:        spb_pkg::CTL_RESET,
        rx_ctl:        spb_pkg::CTL_RESET,
        tx_ctl:        spb_pkg::CTL_RESET,
        rate:          spb_pkg::CTL_RESET,
        div_hi:        8'h00,
        div_lo:        8'h00,
        buf_data:      8'h00,
        buf_full:      1'b0,
        tx_empty_flag: 1'b1,
        rx_ready_flag: 1'b0,
        tx_st:         spb_pkg::TX_IDLE,
        sh:            14'h3fff,
        bits_left:     4'h0,
        is_break:      1'b0,
        phase:         1'b0,
        rx_s1:         1'b1,
        rx_s2:         1'b1,
        rx_s3:         1'b1,
        rx_level:      1'b1,
        wake_seen:     1'b0,
        data_line:     1'b1,
        data_oe_n:     1'b1,
        clk_line:      1'b1,
        clk_oe_n:      1'b1,
        prdata:        32'h0000_0000,
        perr:          1'b0
    };

    spb_state_t st_r;
    spb_state_t st_nxt;

    logic        tick;
    logic        load_ev;
    logic [5:0]  pre_max;
    logic [15:0] divisor;

    logic       setup_ph;
    logic       access_ph;
    logic       wr_acc;
    logic       rd_acc;
    logic [7:0] ofs;
    logic       high_zero;
    logic [7:0] wbyte;
    logic       port_en;
    logic       is_sync;
    logic       sync_master;
    logic       rx_on;
    logic       tx_en;
    logic       fall_ev;
    logic       rise_ev;
    logic       brk_done;

    // ==========================================================================
    // Bus decode
    assign setup_ph  = psel_in && !penable_in;
    assign access_ph = psel_in && penable_in;
    assign wr_acc    = access_ph && pwrite_in;
    assign rd_acc    = access_ph && !pwrite_in;
    assign ofs       = paddr_in[7:0];
    assign high_zero = (paddr_in >> 8) == '0;
    assign wbyte     = pwdata_in[7:0];

    assign port_en     = st_r.rx_ctl[spb_pkg::BIT_PORT_EN];
    assign is_sync     = st_r.tx_ctl[spb_pkg::BIT_SYNC];
    assign sync_master = is_sync && st_r.tx_ctl[spb_pkg::BIT_CLK_MASTER] && port_en;
    assign rx_on       = st_r.rx_ctl[spb_pkg::BIT_RX_SINGLE] || st_r.rx_ctl[spb_pkg::BIT_RX_CONT];
    assign tx_en       = st_r.tx_ctl[spb_pkg::BIT_TX_EN];

    // ==========================================================================
    // Receive line edges, judged only once the second and third stages agree
    assign fall_ev = st_r.rx_level && (st_r.rx_s2 == st_r.rx_s3) && !st_r.rx_s3;
    assign rise_ev = !st_r.rx_level && (st_r.rx_s2 == st_r.rx_s3) && st_r.rx_s3;

    // Slave mode and synchronous reception are not served, so neither may load
    assign load_ev = (st_r.tx_st == spb_pkg::TX_IDLE) && st_r.buf_full && tx_en && port_en
                     && !(wr_acc && ofs == spb_pkg::OFS_TX_BUF)
                     && !(is_sync && !st_r.tx_ctl[spb_pkg::BIT_CLK_MASTER])
                     && !(is_sync && rx_on);

    assign brk_done = tick && (st_r.tx_st == spb_pkg::TX_ASYNC) && st_r.is_break
                      && (st_r.bits_left == 4'h1);

    always_comb begin
        if (is_sync) begin
            pre_max = spb_pkg::PRE_SYNC;
        end else if (st_r.rate[spb_pkg::BIT_WIDE_DIV] && st_r.tx_ctl[spb_pkg::BIT_HIGH_RATE]) begin
            pre_max = spb_pkg::PRE_FAST;
        end else if (st_r.rate[spb_pkg::BIT_WIDE_DIV] || st_r.tx_ctl[spb_pkg::BIT_HIGH_RATE]) begin
            pre_max = spb_pkg::PRE_MID;
        end else begin
            pre_max = spb_pkg::PRE_SLOW;
        end
        divisor = st_r.rate[spb_pkg::BIT_WIDE_DIV] ? {st_r.div_hi, st_r.div_lo}
                                                   : {8'h00, st_r.div_lo};
    end

    spb_baud_div i_div (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .restart_in (load_ev),
        .divisor_in (divisor),
        .pre_max_in (pre_max),
        .tick_out   (tick)
    );

    // ==========================================================================
    // Next state
    always_comb begin
        st_nxt = st_r;

        // Register writes
        if (wr_acc && high_zero) begin
            unique case (ofs)
                spb_pkg::OFS_IRQ_EN: st_nxt.irq_en = wbyte;
                spb_pkg::OFS_RX_CTL: st_nxt.rx_ctl = wbyte & spb_pkg::RX_CTL_WR_MASK;
                spb_pkg::OFS_TX_BUF: begin
                    st_nxt.buf_data      = wbyte;
                    st_nxt.buf_full      = 1'b1;
                    st_nxt.tx_empty_flag = 1'b0;
                end
                spb_pkg::OFS_TX_CTL: st_nxt.tx_ctl = wbyte & spb_pkg::TX_CTL_WR_MASK;
                spb_pkg::OFS_RATE:   st_nxt.rate   = wbyte & spb_pkg::RATE_WR_MASK;
                spb_pkg::OFS_DIV_HI: st_nxt.div_hi = wbyte;
                spb_pkg::OFS_DIV_LO: st_nxt.div_lo = wbyte;
                default: ;
            endcase
        end

        // Reading the receive buffer drops the flag; the data is dummy
        if (rd_acc && high_zero && ofs == spb_pkg::OFS_RX_BUF) begin
            st_nxt.rx_ready_flag = 1'b0;
        end

        // Receive line synchroniser
        st_nxt.rx_s1 = shift_data_pin_in;
        st_nxt.rx_s2 = st_r.rx_s1;
        st_nxt.rx_s3 = st_r.rx_s2;
        if (st_r.rx_s2 == st_r.rx_s3) begin
            st_nxt.rx_level = st_r.rx_s3;
        end

        // Wake watch: pure edge logic, no dependence on core phase clocks
        if (!st_r.rate[spb_pkg::BIT_WAKE_ARM]) begin
            st_nxt.wake_seen = 1'b0;
        end else if (port_en && !is_sync) begin
            if (!st_r.wake_seen && fall_ev) begin
                st_nxt.wake_seen     = 1'b1;
                st_nxt.rx_ready_flag = 1'b1;
            end else if (st_r.wake_seen && rise_ev) begin
                st_nxt.wake_seen                   = 1'b0;
                st_nxt.rate[spb_pkg::BIT_WAKE_ARM] = 1'b0;
            end
        end

        // Shifter
        if (load_ev) begin
            st_nxt.buf_full      = 1'b0;
            st_nxt.tx_empty_flag = 1'b1;
            st_nxt.phase         = 1'b0;
            st_nxt.is_break      = 1'b0;
            if (is_sync) begin
                st_nxt.tx_st     = spb_pkg::TX_SYNC;
                st_nxt.sh        = {5'h1f, st_r.tx_ctl[spb_pkg::BIT_NINTH], st_r.buf_data};
                st_nxt.bits_left = st_r.tx_ctl[spb_pkg::BIT_NINE_TX] ? spb_pkg::BITS_SYNC9
                                                                     : spb_pkg::BITS_SYNC8;
            end else begin
                st_nxt.tx_st = spb_pkg::TX_ASYNC;
                if (st_r.tx_ctl[spb_pkg::BIT_BRK_SEND]) begin
                    // Data byte is deliberately dropped here
                    st_nxt.is_break  = 1'b1;
                    st_nxt.sh        = {1'b1, 13'h0000};
                    st_nxt.bits_left = spb_pkg::BITS_BREAK;
                end else if (st_r.tx_ctl[spb_pkg::BIT_NINE_TX]) begin
                    st_nxt.sh        = {4'hf, st_r.tx_ctl[spb_pkg::BIT_NINTH],
                                        st_r.buf_data, 1'b0};
                    st_nxt.bits_left = spb_pkg::BITS_ASYNC9;
                end else begin
                    st_nxt.sh        = {5'h1f, st_r.buf_data, 1'b0};
                    st_nxt.bits_left = spb_pkg::BITS_ASYNC8;
                end
            end
        end else if (tick && st_r.tx_st == spb_pkg::TX_ASYNC) begin
            if (st_r.bits_left == 4'h1) begin
                st_nxt.tx_st = spb_pkg::TX_IDLE;
            end else begin
                st_nxt.sh        = {1'b1, st_r.sh[13:1]};
                st_nxt.bits_left = st_r.bits_left - 4'h1;
            end
        end else if (tick && st_r.tx_st == spb_pkg::TX_SYNC) begin
            st_nxt.phase = !st_r.phase;
            if (st_r.phase) begin
                if (st_r.bits_left == 4'h1) begin
                    st_nxt.tx_st = spb_pkg::TX_IDLE;
                end else begin
                    st_nxt.sh        = {1'b1, st_r.sh[13:1]};
                    st_nxt.bits_left = st_r.bits_left - 4'h1;
                end
            end
        end

        // Stop bit of the break is out: release the queued byte as normal data
        if (brk_done) begin
            st_nxt.tx_ctl[spb_pkg::BIT_BRK_SEND] = 1'b0;
        end

        // Pins
        st_nxt.data_line = (st_nxt.tx_st != spb_pkg::TX_IDLE) ? st_nxt.sh[0] : 1'b1;
        if (sync_master) begin
            st_nxt.clk_line = st_r.rate[spb_pkg::BIT_CLK_POL]
                              ^ ((st_nxt.tx_st == spb_pkg::TX_SYNC) && st_nxt.phase);
            st_nxt.clk_oe_n  = 1'b0;
            st_nxt.data_oe_n = !(tx_en && !rx_on);
        end else begin
            st_nxt.clk_line  = st_nxt.data_line;
            st_nxt.clk_oe_n  = !(port_en && !is_sync);
            st_nxt.data_oe_n = 1'b1;
        end

        // Read data is prepared in the setup phase so it leaves a flip-flop
        if (setup_ph) begin
            st_nxt.perr   = 1'b0;
            st_nxt.prdata = 32'h0000_0000;
            if (!high_zero) begin
                st_nxt.perr = 1'b1;
            end else begin
                unique case (ofs)
                    spb_pkg::OFS_FLAGS: begin
                        st_nxt.prdata[spb_pkg::BIT_RX_READY] = st_r.rx_ready_flag;
                        st_nxt.prdata[spb_pkg::BIT_TX_EMPTY] = st_r.tx_empty_flag;
                    end
                    spb_pkg::OFS_IRQ_EN: st_nxt.prdata[7:0] = st_r.irq_en;
                    spb_pkg::OFS_RX_CTL: st_nxt.prdata[7:0] = st_r.rx_ctl;
                    spb_pkg::OFS_TX_BUF: st_nxt.prdata[7:0] = st_r.buf_data;
                    spb_pkg::OFS_TX_CTL: begin
                        st_nxt.prdata[7:0] = st_r.tx_ctl;
                        st_nxt.prdata[spb_pkg::BIT_SH_EMPTY] =
                            (st_r.tx_st == spb_pkg::TX_IDLE);
                    end
                    spb_pkg::OFS_RATE: begin
                        st_nxt.prdata[7:0] = st_r.rate;
                        st_nxt.prdata[spb_pkg::BIT_RX_IDLE] = !st_r.wake_seen;
                    end
                    spb_pkg::OFS_DIV_HI: st_nxt.prdata[7:0] = st_r.div_hi;
                    spb_pkg::OFS_DIV_LO: st_nxt.prdata[7:0] = st_r.div_lo;
                    spb_pkg::OFS_RX_BUF: ;
                    default:             st_nxt.perr = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================================
    // Outputs
    assign pready_out               = access_ph;
    assign prdata_out               = st_r.prdata;
    assign pslverr_out              = access_ph && st_r.perr;
    assign shift_data_pin_out       = st_r.data_line;
    assign shift_data_pin_oe_n_out  = st_r.data_oe_n;
    assign shift_clock_pin_out      = st_r.clk_line;
    assign shift_clock_pin_oe_n_out = st_r.clk_oe_n;

    // ==========================================================================
    // Checks
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    wake_flag_set_a: assert property (
        (st_r.rate[spb_pkg::BIT_WAKE_ARM] && port_en && !is_sync && !st_r.wake_seen && fall_ev)
        |=> st_r.rx_ready_flag && st_r.wake_seen)
        else $error("wake edge did not raise the receive flag");

    wake_arm_clear_a: assert property (
        $fell(st_r.rate[spb_pkg::BIT_WAKE_ARM]) && !$past(wr_acc)
        |-> $past(st_r.wake_seen && rise_ev))
        else $error("wake arm cleared without a rising edge");

    rx_flag_clear_a: assert property (
        $fell(st_r.rx_ready_flag) |-> $past(rd_acc && ofs == spb_pkg::OFS_RX_BUF))
        else $error("receive flag dropped without a buffer read");

    break_frame_a: assert property (
        load_ev && !is_sync && st_r.tx_ctl[spb_pkg::BIT_BRK_SEND]
        |=> st_r.is_break && st_r.bits_left == 4'he && st_r.sh == 14'h2000)
        else $error("break frame not fourteen bits of which thirteen low");

    break_send_clear_a: assert property (
        $fell(st_r.tx_ctl[spb_pkg::BIT_BRK_SEND]) && !$past(wr_acc)
        |-> $past(brk_done) && st_r.tx_st == spb_pkg::TX_IDLE)
        else $error("break-send cleared at the wrong time");

    reload_idle_a: assert property (
        load_ev |-> st_r.tx_st == spb_pkg::TX_IDLE ##1 st_r.tx_st != spb_pkg::TX_IDLE)
        else $error("shifter reloaded while busy");

    buf_flag_set_a: assert property (
        $rose(st_r.tx_empty_flag) |-> $past(load_ev) && !st_r.buf_full)
        else $error("buffer-empty flag set without a transfer");

    buf_flag_clear_a: assert property (
        $fell(st_r.tx_empty_flag) |-> $past(wr_acc && ofs == spb_pkg::OFS_TX_BUF))
        else $error("buffer-empty flag cleared without a buffer write");

    half_duplex_a: assert property (
        (is_sync && rx_on && st_r.tx_st == spb_pkg::TX_IDLE)
        |=> st_r.tx_st == spb_pkg::TX_IDLE && st_r.data_oe_n)
        else $error("transmit started while receive enabled");

    clock_idle_a: assert property (
        (sync_master && st_r.tx_st == spb_pkg::TX_IDLE) [*2]
        |-> st_r.clk_line == st_r.rate[spb_pkg::BIT_CLK_POL] && !st_r.clk_oe_n)
        else $error("shift clock not at its idle level");

endmodule

// ==== dv/spb_peer.sv ====
// Serial peer: drives the receive line, decodes async frames from the transmit line
module spb_peer #(
    parameter int BIT_CYC = 16
) (
    input  wire logic clk_in,
    input  wire logic line_in,
    output logic      rx_line_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] frames[$];
    logic [9:0] sh;
    int         low_run = 0;
    int         longest_low = 0;
    initial rx_line_out = 1'b1;
    task automatic set_line(input logic v);
        rx_line_out <= v;
    endtask
    // ==========================================================================
    // Longest low run shows the break length
    // Counted on the falling clock edge, not the edge that moves the pin, so no race
    always @(negedge clk_in) begin
        low_run = line_in ? 0 : low_run + 1;
        if (low_run > longest_low)
            longest_low = low_run;
    end
    // Mid-bit sampling; a break reads as stop bit low
    always begin
        @(negedge line_in);
        repeat (BIT_CYC / 2) @(posedge clk_in);
        for (int i = 0; i < 10; i++) begin
            sh[i] = line_in;
            repeat (BIT_CYC) @(posedge clk_in);
        end
        frames.push_back(sh);
        wait (line_in === 1'b1);
    end
endmodule

// ==== dv/testbench.sv ====
// Register-level bench of the break and sync master transmit port
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_data;
    logic        pready, pslverr, rd_err, dt_out, dt_oe_n, ck_out, ck_oe_n, rx_line;
    logic [17:0] cap;
    int          n_fail = 0;
    int          n_compared = 0;
    int          cycles = 0;
    always #25 clk = ~clk;
    spb_top dut (.sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .shift_data_pin_in(dt_oe_n ? rx_line : dt_out), .shift_data_pin_out(dt_out),
        .shift_data_pin_oe_n_out(dt_oe_n), .shift_clock_pin_out(ck_out),
        .shift_clock_pin_oe_n_out(ck_oe_n));
    spb_peer #(.BIT_CYC(16)) peer (.clk_in(clk), .line_in(ck_out), .rx_line_out(rx_line));
    // ==========================================================================
    // Bus tasks
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(rd_data, e)
    endtask
    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, run needs under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            end_of_test();
        end
    end
    // ==========================================================================
    // Tests
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(12'h000, 32'h10);
        rd_chk(12'h014, 32'h40);
        apb(1'b1, 12'h000, 8'h00);
        rd_chk(12'h000, 32'h10);
        apb(1'b1, 12'h010, 8'h02);
        rd_chk(12'h010, 32'h02);
        rd_chk(12'h124, 32'h0);
        `CHK(rd_err, 1'b1)
        apb(1'b1, 12'h008, 8'h80);
        apb(1'b1, 12'h014, 8'h02);
        peer.set_line(1'b0);
        repeat (6) @(posedge clk);
        rd_chk(12'h000, 32'h30);
        rd_chk(12'h014, 32'h02);
        peer.set_line(1'b1);
        repeat (6) @(posedge clk);
        rd_chk(12'h014, 32'h40);
        rd_chk(12'h020, 32'h0);
        rd_chk(12'h000, 32'h10);
        apb(1'b1, 12'h01c, 8'h00);
        apb(1'b1, 12'h010, 8'h2c);
        apb(1'b1, 12'h00c, 8'hff);
        apb(1'b1, 12'h00c, 8'h55);
        rd_chk(12'h010, 32'h2c);
        rd_chk(12'h000, 32'h00);
        while (peer.frames.size() < 2) @(posedge clk);
        `CHK(peer.frames[0], 10'h000)
        `CHK(peer.frames[1], 10'h2aa)
        `CHK(peer.longest_low, 209)
        `CHK(peer.longest_low * 9 / (13 * 16), 9)
        rd_chk(12'h010, 32'h26);
        rd_chk(12'h000, 32'h10);
        apb(1'b1, 12'h014, 8'h01);
        rd_chk(12'h014, 32'h41);
        apb(1'b1, 12'h008, 8'h90);
        apb(1'b1, 12'h014, 8'h10);
        apb(1'b1, 12'h010, 8'hf1);
        apb(1'b1, 12'h004, 8'h10);
        rd_chk(12'h004, 32'h10);
        apb(1'b1, 12'h00c, 8'ha5);
        `CHK({ck_out, ck_oe_n, dt_oe_n}, 3'b101)
        rd_chk(12'h000, 32'h00);
        fork
            for (int i = 0; i < 18; i++) begin
                @(negedge ck_out);
                cap[i] = dt_out;
            end
        join_none
        apb(1'b1, 12'h008, 8'h80);
        apb(1'b1, 12'h00c, 8'h3c);
        rd_chk(12'h000, 32'h00);
        wait fork;
        // Last bit still stands for two cycles after its clock edge
        repeat (4) @(posedge clk);
        `CHK(cap, {9'h13c, 9'h1a5})
        rd_chk(12'h010, 32'hf3);
        `CHK({ck_out, dt_oe_n}, 2'b10)
        end_of_test();
    end
endmodule
